//--- common/patch_params.svh
// Constants for the ROM patch redirect unit
`ifndef PATCH_PARAMS_SVH
`define PATCH_PARAMS_SVH

`define PATCH_SLOTS          4
`define PATCH_ADDR_W         15
`define PATCH_REG_W          16
`define PATCH_ENABLE_BIT     15
`define PATCH_JUMP_W         32
`define PATCH_ALIGN_BITS     3
// Register map, word addresses on the plain register port
`define PATCH_REG_AW         4
`define PATCH_OFF_START0     4'h0
`define PATCH_OFF_JUMP0_LO   4'h4
`define PATCH_OFF_JUMP0_HI   4'h8
`define PATCH_OFF_STATUS     4'hc
`define PATCH_OFF_HITCNT     4'hd
`define PATCH_ENABLE_RST     1'b0
`define PATCH_STATUS_W       8

`endif

//--- common/patch_pkg.sv
// Types shared by the ROM patch redirect unit
package patch_pkg;

    // One fetch request from the core
    typedef struct packed {
        logic        valid;
        logic [14:0] pc;
    } fetch_req_t;

    // Redirect answer to the core
    typedef struct packed {
        logic        redirect;
        logic [1:0]  slot;
        logic [31:0] jump_word;
    } redirect_t;

    // Fetch latency tracking state
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ROM     = 2'b01,
        ST_PATCHED = 2'b10
    } fetch_state_t;

endpackage : patch_pkg

//--- design/patch_slot.sv
// One patch slot: start address and jump word storage with compare
`timescale 1ns/10ps
`include "patch_params.svh"
module patch_slot #(
    parameter int ADDR_W = `PATCH_ADDR_W,
    parameter int JUMP_W = `PATCH_JUMP_W
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // Storage writes
    input  wire logic              i_wr_start,
    input  wire logic              i_wr_jump_lo,
    input  wire logic              i_wr_jump_hi,
    input  wire logic [15:0]       i_wdata,
    // Compare input
    input  wire logic [ADDR_W-1:0] i_pc,
    // Contents and match
    output logic                   o_enable,
    output logic [ADDR_W-1:0]      o_match_address,
    output logic [JUMP_W-1:0]      o_jump_word,
    output logic                   o_hit
);
    logic              enable_ff;
    logic [ADDR_W-1:0] match_address_ff;
    logic [JUMP_W-1:0] jump_word_ff;

    // Enable cleared by reset; address field left unreset on purpose [R3] [R4]
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            enable_ff <= `PATCH_ENABLE_RST;
        end else if (i_wr_start) begin
            enable_ff <= i_wdata[`PATCH_ENABLE_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_wr_start) begin
            match_address_ff <= i_wdata[ADDR_W-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_wr_jump_lo) begin
            jump_word_ff[15:0] <= i_wdata;
        end
        if (i_wr_jump_hi) begin
            jump_word_ff[JUMP_W-1:16] <= i_wdata[JUMP_W-17:0];
        end
    end

    // Disabled slot never hits [R12]
    assign o_hit           = enable_ff && (match_address_ff == i_pc);
    assign o_enable        = enable_ff;
    assign o_match_address = match_address_ff;
    assign o_jump_word     = jump_word_ff;
endmodule // patch_slot

//--- design/patch_priority.sv
// Lowest-index-wins selector over the slot hits
`timescale 1ns/10ps
`include "patch_params.svh"
module patch_priority #(
    parameter int SLOTS = `PATCH_SLOTS
) (
    // Slot hits
    input  wire logic [SLOTS-1:0] i_hit,
    // Winning slot
    output logic                  o_any,
    output logic [1:0]            o_slot
);
    // Scan from the top so the lowest hit is written last [R5]
    always_comb begin
        o_any  = 1'b0;
        o_slot = 2'h0;
        for (int i = SLOTS - 1; i >= 0; i--) begin
            if (i_hit[i]) begin
                o_any  = 1'b1;
                o_slot = 2'(i);
            end
        end
    end
endmodule // patch_priority

//--- design/rom_patch_redirect_unit.sv
// ROM patch redirect unit: four slots, register port and fetch redirect
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "patch_params.svh"

// Summary of operation
// R1: Four independent slots, each with start address and jump word storage.
// R2: Fetch whose PC equals an enabled slot address is redirected to its jump word.
// R3: Start register is 16 bits; bit 15 enables, cleared at reset.
// R4: Bits 14..0 hold the compare address; undefined after reset.
// R5: Several matching slots: the lowest-numbered slot's jump word is used.
// R6: Jump word may point to EEPROM or RAM; unit passes it untouched.
// R7: Startup firmware loads slots before anything else when patches apply.
// R8: Software loads jump words with far-page jump opcode and target.
// R9: Software aligns patch start addresses to 8 bytes.
// R10: Patch routines end with far jump back into ROM.
// R11: Slower patch fetches tolerated; redirect holds until the core signals the fetch done.
// R12: Compare runs on every fetch; disabled slots never redirect.
// R13: Slots are ordinary read/write registers; writes apply to the next fetch.
module rom_patch_redirect_unit #(
    parameter int SLOTS  = `PATCH_SLOTS,
    parameter int ADDR_W = `PATCH_ADDR_W,
    parameter int JUMP_W = `PATCH_JUMP_W
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_srst,
    // Register port
    input  wire logic [`PATCH_REG_AW-1:0] i_reg_addr,
    input  wire logic [15:0]            i_reg_wdata,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    output logic [15:0]                 o_reg_rdata,
    // Fetch path from the core
    input  wire patch_pkg::fetch_req_t  i_fetch,
    input  wire logic                   i_fetch_done,
    // Redirect answer
    output patch_pkg::redirect_t        o_redirect,
    output logic                        o_fetch_busy
);
    import patch_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Slot storage

    logic [SLOTS-1:0]              hit;
    logic [SLOTS-1:0]              slot_en;
    logic [SLOTS-1:0][ADDR_W-1:0]  slot_addr;
    logic [SLOTS-1:0][JUMP_W-1:0]  slot_jump;
    logic                          any_hit;
    logic [1:0]                    win_slot;

    // One slot per generate entry [R1]
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_slot
            logic wr_start;
            logic wr_lo;
            logic wr_hi;
            // Plain register writes, visible at the next fetch [R13]
            assign wr_start = i_reg_wr && (i_reg_addr == `PATCH_OFF_START0 + 4'(g));
            assign wr_lo    = i_reg_wr && (i_reg_addr == `PATCH_OFF_JUMP0_LO + 4'(g));
            assign wr_hi    = i_reg_wr && (i_reg_addr == `PATCH_OFF_JUMP0_HI + 4'(g));
            patch_slot #(
                .ADDR_W (ADDR_W),
                .JUMP_W (JUMP_W)
            ) u_slot (
                .i_clk           (i_clk),
                .i_srst          (i_srst),
                .i_wr_start      (wr_start),
                .i_wr_jump_lo    (wr_lo),
                .i_wr_jump_hi    (wr_hi),
                .i_wdata         (i_reg_wdata),
                .i_pc            (i_fetch.pc),
                .o_enable        (slot_en[g]),
                .o_match_address (slot_addr[g]),
                .o_jump_word     (slot_jump[g]),
                .o_hit           (hit[g])
            );
        end
    endgenerate

    patch_priority #(
        .SLOTS (SLOTS)
    ) u_prio (
        .i_hit  (hit),
        .o_any  (any_hit),
        .o_slot (win_slot)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Fetch redirect

    fetch_state_t state_ff;
    fetch_state_t nxt_state;
    redirect_t         redirect_ff;
    redirect_t         nxt_redirect;
    logic              busy_ff;
    logic              fetch_take;
    logic [JUMP_W-1:0] win_jump;
    logic [7:0]        hit_count_ff;
    logic [1:0]        last_slot_ff;

    // A fetch is taken only while no other one is outstanding
    assign fetch_take = (state_ff == ST_IDLE) && i_fetch.valid;

    // Winning slot's jump word; zero when nothing hits
    always_comb begin
        win_jump = '0;
        if (any_hit) begin
            win_jump = slot_jump[win_slot];
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                // Compare taken on every new fetch [R12]
                if (i_fetch.valid) begin
                    nxt_state = any_hit ? ST_PATCHED : ST_ROM;
                end
            end
            ST_ROM, ST_PATCHED: begin
                // Stay until the core says the fetch landed; EEPROM may be slow [R11]
                if (i_fetch_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Busy has its own flop so the core sees a glitch-free level
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state != ST_IDLE);
        end
    end

    // Answer latched at fetch start and held through a long fetch [R2] [R11]
    always_comb begin
        nxt_redirect = redirect_ff;
        if (fetch_take) begin
            nxt_redirect.redirect  = any_hit;  // [R2]
            nxt_redirect.slot      = win_slot; // [R5]
            // Jump word forwarded as is, EEPROM or RAM target alike [R6]
            nxt_redirect.jump_word = win_jump;
        end else if (i_fetch_done) begin
            nxt_redirect = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            redirect_ff <= '0;
        end else begin
            redirect_ff <= nxt_redirect;
        end
    end

    // Counter wraps; only a rough gauge of patch use
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hit_count_ff <= 8'h00;
        end else if (fetch_take && any_hit) begin
            hit_count_ff <= hit_count_ff + 8'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            last_slot_ff <= 2'h0;
        end else if (fetch_take && any_hit) begin
            last_slot_ff <= win_slot;
        end
    end

    assign o_redirect   = redirect_ff;
    assign o_fetch_busy = busy_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Register readback

    logic [15:0] nxt_rdata;
    logic [15:0] rdata_ff;
    logic [15:0] start_word;
    logic [15:0] jump_lo_word;
    logic [15:0] jump_hi_word;
    logic [15:0] status_word;
    logic [15:0] hitcnt_word;
    logic [1:0]  ridx;

    assign ridx = i_reg_addr[1:0];

    // Per-group words first, so the address mux below stays flat
    assign start_word   = {slot_en[ridx], slot_addr[ridx]};
    assign jump_lo_word = slot_jump[ridx][15:0];
    assign jump_hi_word = slot_jump[ridx][JUMP_W-1:16];
    assign hitcnt_word  = {8'h00, hit_count_ff};

    // Status: [3:0] enables, [5:4] last hit slot, [6] redirect, [7] busy
    always_comb begin
        status_word      = 16'h0000;
        status_word[3:0] = slot_en;
        status_word[5:4] = last_slot_ff;
        status_word[6]   = redirect_ff.redirect;
        status_word[7]   = busy_ff;
    end

    // Readable slot contents plus status; unmapped words read zero [R13]
    always_comb begin
        nxt_rdata = 16'h0000;
        case (i_reg_addr[3:2])
            2'h0: nxt_rdata = start_word;
            2'h1: nxt_rdata = jump_lo_word;
            2'h2: nxt_rdata = jump_hi_word;
            2'h3: begin
                if (i_reg_addr == `PATCH_OFF_STATUS) begin
                    nxt_rdata = status_word;
                end else if (i_reg_addr == `PATCH_OFF_HITCNT) begin
                    nxt_rdata = hitcnt_word;
                end
            end
            default: nxt_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_ff <= 16'h0000;
        end else if (i_reg_rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 16'h0000;
        end
    end

    assign o_reg_rdata = rdata_ff;
endmodule // rom_patch_redirect_unit

//--- testbench/fetch_partner.sv
// Fetch-side partner: completes each outstanding fetch after a set latency
`timescale 1ns/10ps
module fetch_partner (
    // Clock, reset and handshake
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic       i_busy,
    input  wire logic [2:0] i_lat,
    output logic            o_done
);
    logic [2:0] wait_ff;
    // Zero latency acts as ROM; longer ones as the slower EEPROM or RAM path
    always_ff @(posedge i_clk) begin
        if (i_srst || o_done || !i_busy) begin
            o_done  <= 1'b0;
            wait_ff <= 3'h0;
        end else if (wait_ff >= i_lat) begin
            o_done <= 1'b1;
        end else begin
            wait_ff <= wait_ff + 3'h1;
        end
    end
endmodule // fetch_partner

//--- testbench/patch_checker_assertions.sv
// Port assertions for the ROM patch redirect unit
`timescale 1ns/10ps
`include "patch_params.svh"
module patch_checker
    import patch_pkg::*;
#(parameter int SLOTS = `PATCH_SLOTS) (
    // Watched ports
    input wire logic [0:0]  i_clk,
    input wire logic [0:0]  i_srst,
    input wire logic [3:0]  i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic [0:0]  i_reg_wr,
    input wire logic [0:0]  i_reg_rd,
    input wire logic [15:0] o_reg_rdata,
    input wire fetch_req_t  i_fetch,
    input wire logic [0:0]  i_fetch_done,
    input wire redirect_t   o_redirect,
    input wire logic [0:0]  o_fetch_busy
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////////////////////////
    // Shadow of start registers; address fields unknown until written
    logic [15:0]      start_ff [SLOTS];
    logic [SLOTS-1:0] hit_v;
    logic [1:0]       low_slot;
    wire logic        any_hit = |hit_v;
    wire logic        take = i_fetch.valid && !o_fetch_busy;
    wire logic [15:0] rd_shadow = start_ff[i_reg_addr[1:0]];
    always_ff @(posedge i_clk) begin
        for (int n = 0; n < SLOTS; n++) begin
            if (i_srst) begin
                start_ff[n][15] <= 1'b0;
            end else if (i_reg_wr && i_reg_addr == 4'(n)) begin
                start_ff[n] <= i_reg_wdata;
            end
        end
    end
    always_comb begin
        low_slot = 2'h0;
        for (int n = SLOTS - 1; n >= 0; n--) begin
            hit_v[n] = start_ff[n][15] && start_ff[n][14:0] == i_fetch.pc;
            if (hit_v[n]) begin
                low_slot = 2'(n);
            end
        end
    end
    ////////////////////////////////////////////////////////////
    property p_rst;
        disable iff (1'b0)
        i_srst |=> !o_fetch_busy && !o_redirect.redirect;
    endproperty
    a_rst: assert property (p_rst) else $error("active after reset");
    property p_take;
        take |=> o_fetch_busy && o_redirect.redirect == $past(any_hit);
    endproperty
    a_take: assert property (p_take) else $error("wrong redirect decision");
    property p_slot;
        take && any_hit |=> o_redirect.slot == $past(low_slot);
    endproperty
    a_slot: assert property (p_slot) else $error("wrong winning slot");
    property p_hold;
        o_fetch_busy && !i_fetch_done |=> o_fetch_busy && $stable(o_redirect);
    endproperty
    a_hold: assert property (p_hold) else $error("redirect not held");
    property p_end;
        o_fetch_busy && i_fetch_done |=> !o_fetch_busy && !o_redirect.redirect;
    endproperty
    a_end: assert property (p_end) else $error("fetch not closed");
    property p_quiet;
        !o_fetch_busy |-> !o_redirect.redirect;
    endproperty
    a_quiet: assert property (p_quiet) else $error("redirect while idle");
    property p_rdz;
        !i_reg_rd |=> o_reg_rdata == 16'h0;
    endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside read");
    property p_rdst;
        i_reg_rd && i_reg_addr[3:2] == 2'h0 |=> o_reg_rdata == $past(rd_shadow);
    endproperty
    a_rdst: assert property (p_rdst) else $error("start register readback");
    c_last: cover property (take && any_hit && low_slot == 2'h3);
    c_prio: cover property (take && hit_v[0] && hit_v[3]);
    c_slow: cover property (o_fetch_busy [*4]);
endmodule // patch_checker

bind rom_patch_redirect_unit patch_checker #(.SLOTS(SLOTS)) u_chk (.i_clk(i_clk),
    .i_srst(i_srst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_fetch(i_fetch),
    .i_fetch_done(i_fetch_done), .o_redirect(o_redirect), .o_fetch_busy(o_fetch_busy));

//--- testbench/tb_top.sv
// Self-checking bench for the ROM patch redirect unit
`timescale 1ns/10ps
`define CHECK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
end
module tb_top;
    import patch_pkg::*;
    localparam logic [7:0] FAR_OP = 8'h5a; // Far-page jump opcode, value arbitrary
    logic        clk, srst, wr, rd, done, busy;
    logic        rd_seen = 1'b0;
    logic        busy_seen = 1'b0;
    logic [3:0]  ra;
    logic [2:0]  lat;
    logic [7:0]  hits = 8'h00;
    logic [1:0]  lastw = 2'h0;
    logic [15:0] wd, rdat, got_r;
    logic [15:0] st [4];
    logic [31:0] jw [4];
    logic [3:0]  grp [3] = '{4'b0011, 4'b1001, 4'b1110};
    fetch_req_t  fet;
    redirect_t   rdr, got_e;
    logic [15:0] rq [$];
    redirect_t   fq [$];
    int          error_cnt = 0;
    int          num_checks = 0;
    rom_patch_redirect_unit uut (.i_clk(clk), .i_srst(srst), .i_reg_addr(ra), .i_reg_wdata(wd),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_fetch(fet), .i_fetch_done(done),
        .o_redirect(rdr), .o_fetch_busy(busy));
    fetch_partner u_far (.i_clk(clk), .i_srst(srst), .i_busy(busy), .i_lat(lat), .o_done(done));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rst();
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        for (int n = 0; n < 4; n++) st[n][15] = 1'b0;
        hits = 8'h00;
        lastw = 2'h0;
    endtask
    // Expected read word from the shadow; status is read only while idle
    function automatic logic [15:0] exp_rd(input logic [3:0] a);
        case (a[3:2])
            2'h0: return st[a[1:0]];
            2'h1: return jw[a[1:0]][15:0];
            2'h2: return jw[a[1:0]][31:16];
            default: begin
                if (a == 4'hc) return {10'h000, lastw, st[3][15], st[2][15], st[1][15], st[0][15]};
                return (a == 4'hd) ? {8'h00, hits} : 16'h0000;
            end
        endcase
    endfunction
    // One-cycle strobe then an idle cycle, so strobes never collide
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        if (!w) rq.push_back(exp_rd(a));
        {wr, rd, ra, wd} <= {w, !w, a, d};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        @(posedge clk);
        if (w && a[3:2] == 2'h0) st[a[1:0]] = d;
        if (w && a[3:2] == 2'h1) jw[a[1:0]][15:0] = d;
        if (w && a[3:2] == 2'h2) jw[a[1:0]][31:16] = d;
    endtask
    task automatic fetch(input logic [14:0] pc);
        redirect_t e;
        e = '0;
        for (int n = 3; n >= 0; n--)
            if (st[n][15] === 1'b1 && st[n][14:0] === pc) e = {1'b1, 2'(n), jw[n]};
        fq.push_back(e);
        if (e.redirect) begin
            hits++;
            lastw = e.slot;
        end
        fet <= {1'b1, pc};
        lat <= 3'($urandom_range(0, 5));
        @(posedge clk);
        fet <= {1'b0, 15'($urandom)};
        for (int k = 0; k < 30 && (k == 0 || busy); k++) @(posedge clk);
        if (busy) error_cnt++;
    endtask
    always @(posedge clk) begin
        if (rd_seen) begin
            got_r = rq.pop_front();
            `CHECK(rdat, got_r)
        end
        if (busy && !busy_seen) begin
            got_e = fq.pop_front();
            `CHECK(got_e.redirect ? rdr : {rdr.redirect, 34'h0}, got_e)
        end
        rd_seen <= rd;
        busy_seen <= busy;
    end
    initial begin
        srst = 1'b1;
        {wr, rd, ra, wd, fet, lat} = '0;
        void'($urandom(32'haf71));
        rst();
        bus(1'b1, 4'h1, 16'h0120);
        fetch(15'h0120);
        $display("test disabled slot done");
        for (int n = 0; n < 4; n++) begin
            bus(1'b1, 4'(n), {1'b1, 12'($urandom), 3'h0});
            bus(1'b1, 4'(4 + n), 16'($urandom));
            bus(1'b1, 4'(8 + n), {FAR_OP, 8'($urandom)});
        end
        bus(1'b1, 4'he, 16'hffff);
        for (int a = 0; a < 16; a++) bus(1'b0, 4'(a), 16'h0);
        for (int n = 0; n < 4; n++) begin
            fetch(st[n][14:0]);
            fetch(st[n][14:0] + 15'h8);
        end
        $display("test load and redirect done");
        foreach (grp[g]) begin
            for (int n = 0; n < 4; n++) bus(1'b1, 4'(n), {1'b1, grp[g][n] ? 15'h200 : 15'h208});
            fetch(15'h0200);
            fetch(15'h0208);
        end
        $display("test priority done");
        repeat (40) begin
            bus(1'b1, 4'($urandom), {1'($urandom), 9'h0, 3'($urandom), 3'h0});
            fetch({9'h0, 3'($urandom), 3'h0});
            bus(1'b0, 4'($urandom), 16'h0);
        end
        $display("test random done");
        bus(1'b1, 4'h0, 16'h8040);
        rst();
        fetch(15'h0040);
        bus(1'b0, 4'h0, 16'h0);
        bus(1'b0, 4'hc, 16'h0);
        bus(1'b0, 4'hd, 16'h0);
        $display("test reset done");
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
endmodule // tb_top
